// ===== common/cpoa_pkg.sv
// Constants, field layouts and types for the core pipeline and operand addressing block.
// Assumes a single 25 MHz core clock and a plain software register port.
package cpoa_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PC_W   = 20;                 // Program word address width
    localparam int IW_W   = 16;                 // Instruction word width
    localparam int DA_W   = 12;                 // Data address width
    localparam int BANK_W = 4;                  // Bank select width
    localparam int RD_W   = 32;                 // Register port data width
    localparam int RA_W   = 8;                  // Register port address width

    // ****************************************************************
    // Instruction fields and kinds
    // ****************************************************************
    localparam int KIND_HI = 15;
    localparam int KIND_LO = 12;
    localparam int FN_HI   = 11;
    localparam int FN_LO   = 10;
    localparam int D_BIT   = 9;                 // Destination select
    localparam int A_BIT   = 8;                 // Access select
    localparam logic [3:0] K_INH   = 4'h0;      // Inherent
    localparam logic [3:0] K_LIT   = 4'h1;      // Literal to accumulator
    localparam logic [3:0] K_BYTE  = 4'h2;      // Byte op with d and a
    localparam logic [3:0] K_STORE = 4'h3;      // Accumulator to register, implied dest
    localparam logic [3:0] K_FULL  = 4'h4;      // Full 12-bit source address move
    localparam logic [3:0] K_BANK  = 4'h5;      // Literal to bank select
    localparam logic [3:0] K_JUMP  = 4'hE;      // Absolute jump, target bits 7:0
    localparam logic [3:0] K_JHI   = 4'hF;      // Second word, target bits 19:8
    localparam logic [1:0] FN_MOV  = 2'h0;
    localparam logic [1:0] FN_INC  = 2'h1;
    localparam logic [1:0] FN_DEC  = 2'h2;
    localparam logic [1:0] FN_CLR  = 2'h3;
    localparam logic [15:0] NOP_WORD   = 16'h0000;
    localparam logic [7:0]  INH_CLRACC = 8'h01;

    // ****************************************************************
    // Data space map
    // ****************************************************************
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;   // Low access RAM below, SFRs above
    localparam logic [3:0]  ACCESS_HIGH  = 4'hF;    // Bank of the upper access region
    localparam logic [11:0] PTR_BASE0    = 12'hFE8;
    localparam logic [11:0] PTR_BASE1    = 12'hFD8;
    localparam logic [2:0]  OFS_LO       = 3'h1;
    localparam logic [2:0]  OFS_HI       = 3'h2;
    localparam logic [2:0]  OFS_PLUSW    = 3'h3;
    localparam logic [2:0]  OFS_PREINC   = 3'h4;
    localparam logic [2:0]  OFS_POSTDEC  = 3'h5;
    localparam logic [2:0]  OFS_POSTINC  = 3'h6;
    localparam logic [2:0]  OFS_PLAIN    = 3'h7;

    // ****************************************************************
    // Software registers and reset values
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;   // Bit 0: extended_set_enable
    localparam logic [7:0] REG_BANK = 8'h04;   // bank_select_register
    localparam logic [7:0] REG_PC   = 8'h08;   // program_counter, read only
    localparam logic [7:0] REG_ACC  = 8'h0C;   // Working accumulator, read only
    localparam logic [7:0] REG_IR   = 8'h10;   // instruction_holding_register, read only
    localparam int         CTRL_EXT = 0;
    localparam logic [PC_W-1:0]   PC_RST   = 20'h00000;
    localparam logic [BANK_W-1:0] BANK_RST = 4'h0;
    localparam logic [7:0]        ACC_RST  = 8'h00;

    // Pointer access mode resolved from an alias address
    typedef enum logic [2:0] {
        PM_NONE, PM_PLAIN, PM_POSTINC, PM_POSTDEC, PM_PREINC, PM_PLUSW
    } cpoa_pmode_t;

endpackage : cpoa_pkg

// ===== design/cpoa_phase_gen.sv
// Four-phase sequencer for the instruction cycle.
// Assumes the core clock is the input clock; one phase lasts one clock.
`timescale 1ns/1ps
module cpoa_phase_gen
    import cpoa_pkg::*;
(
    input  wire logic       clk,    // Core clock
    input  wire logic       rst_n,  // Async reset, active low
    output logic [3:0]      phase   // One-hot: bit 0 phase_one .. bit 3 phase_four
);

    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cpoa_phase_t;

    cpoa_phase_t state;
    cpoa_phase_t next_state;

    // ****************************************************************
    // Divide by four
    // ****************************************************************
    // Phases advance strictly one to four, so they can never overlap
    always_comb begin
        unique case (state)
            PH_ONE:   next_state = PH_TWO;
            PH_TWO:   next_state = PH_THREE;
            PH_THREE: next_state = PH_FOUR;
            PH_FOUR:  next_state = PH_ONE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PH_ONE;
        end else begin
            state <= next_state;
        end
    end

    // One-hot phase lines
    always_comb begin
        unique case (state)
            PH_ONE:   phase = 4'h1;
            PH_TWO:   phase = 4'h2;
            PH_THREE: phase = 4'h4;
            PH_FOUR:  phase = 4'h8;
        endcase
    end

endmodule : cpoa_phase_gen

// ===== design/cpoa_ptr_file.sv
// Pointer register file: two 12-bit data pointers.
// Assumes one write per instruction cycle from the pipeline.
`timescale 1ns/1ps
module cpoa_ptr_file
    import cpoa_pkg::*;
(
    input  wire logic            clk,     // Core clock
    input  wire logic            rst_n,   // Async reset, active low
    input  wire logic            wrEn,    // Write strobe
    input  wire logic            wrIdx,   // Pointer selected for write
    input  wire logic [DA_W-1:0] wrValue, // New full pointer value
    output logic      [DA_W-1:0] ptr0,    // Pointer 0
    output logic      [DA_W-1:0] ptr1     // Pointer 1
);

    logic [DA_W-1:0] next_ptr0;
    logic [DA_W-1:0] next_ptr1;

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Whole 12-bit value written so modify carries cross the byte boundary
    always_comb begin
        next_ptr0 = ptr0;
        next_ptr1 = ptr1;
        if (wrEn && !wrIdx) begin
            next_ptr0 = wrValue;
        end
        if (wrEn && wrIdx) begin
            next_ptr1 = wrValue;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr0 <= 12'h000;
            ptr1 <= 12'h000;
        end else begin
            ptr0 <= next_ptr0;
            ptr1 <= next_ptr1;
        end
    end

endmodule : cpoa_ptr_file

// ===== design/cpoa_core_pipe.sv
// Instruction pipeline and data operand address generation of an 8-bit core.
// Assumes program memory answers within the cycle, data RAM one clock after a read.
// Functional notes
// - Input clock divided into four phases
// - Instruction cycle runs phase one to four
// - Fetch overlaps execute of previous instruction
// - PC change flushes fetched word, two cycles
// - Program counter increments in phase one
// - Opcode captured phase one, executed two-four
// - Operand read phase two, write phase four
// - Inherent instructions take no operand field
// - Jump carries a 20-bit target address
// - Direct address from opcode low byte
// - Access bit one: bank plus address
// - Access bit zero: fixed access bank
// - Full 12-bit address ignores bank select
// - Destination bit picks register or accumulator
// - No destination bit: implied destination
// - Pointers address data, are memory mapped
// - Aliases increment, decrement or offset pointer
// - Indexed offset mode only when extension enabled
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cpoa_core_pipe
    import cpoa_pkg::*;
(
    input  wire logic              clk,      // Core clock, 25 MHz
    input  wire logic              rst_n,    // Async reset, active low
    output logic      [PC_W-1:0]   progAddr, // Program memory word address
    input  wire logic [IW_W-1:0]   progData, // Program memory word
    output logic      [DA_W-1:0]   ramAddr,  // Data RAM address
    output logic                   ramRead,  // Data RAM read strobe
    output logic                   ramWrite, // Data RAM write strobe
    output logic      [7:0]        ramWdata, // Data RAM write data
    input  wire logic [7:0]        ramRdata, // Data RAM read data, one clock after read
    input  wire logic [RA_W-1:0]   regAddr,  // Register port address
    input  wire logic [RD_W-1:0]   regWdata, // Register port write data
    input  wire logic              regWrite, // Register port write strobe
    input  wire logic              regRead,  // Register port read strobe
    output logic      [RD_W-1:0]   regRdata  // Register port read data
);

    logic [3:0]        phase;
    logic [DA_W-1:0]   ptr0;
    logic [DA_W-1:0]   ptr1;
    logic              ptrWrEn;
    logic              ptrWrIdx;
    logic [DA_W-1:0]   ptrWrValue;

    logic [PC_W-1:0]   pc,        next_pc;
    logic [IW_W-1:0]   ir,        next_ir;
    logic [IW_W-1:0]   fetchReg,  next_fetchReg;
    logic              flush,     next_flush;
    logic [7:0]        acc,       next_acc;
    logic [BANK_W-1:0] bank,      next_bank;
    logic              extEn,     next_extEn;
    logic [DA_W-1:0]   effAddr,   next_effAddr;
    cpoa_pmode_t       pmode,     next_pmode;
    logic              pidx,      next_pidx;
    logic [DA_W-1:0]   ptrNew,    next_ptrNew;
    logic              mapLo,     next_mapLo;
    logic              mapHi,     next_mapHi;
    logic [7:0]        result,    next_result;
    logic              toAcc,     next_toAcc;
    logic              toMem,     next_toMem;
    logic [PC_W-1:0]   next_progAddr;
    logic [DA_W-1:0]   next_ramAddr;
    logic              next_ramRead;
    logic              next_ramWrite;
    logic [7:0]        next_ramWdata;
    logic [RD_W-1:0]   next_regRdata;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Direct operand address from the opcode low byte
    function automatic logic [DA_W-1:0] directAddr(
        input logic [IW_W-1:0]   op,
        input logic [BANK_W-1:0] bk,
        input logic              ext,
        input logic [DA_W-1:0]   p1
    );
        logic [7:0] lit;
        lit = op[7:0];
        if (op[A_BIT]) begin
            directAddr = {bk, lit};
        end else if (ext && (lit < ACCESS_SPLIT)) begin
            directAddr = DA_W'(p1 + {4'h0, lit});
        end else if (lit < ACCESS_SPLIT) begin
            directAddr = {4'h0, lit};
        end else begin
            directAddr = {ACCESS_HIGH, lit};
        end
    endfunction : directAddr

    // Which pointer alias, if any, an address names
    function automatic cpoa_pmode_t aliasMode(input logic [DA_W-1:0] a);
        aliasMode = PM_NONE;
        if ((a[11:3] == PTR_BASE0[11:3]) || (a[11:3] == PTR_BASE1[11:3])) begin
            unique case (a[2:0])
                OFS_PLAIN:   aliasMode = PM_PLAIN;
                OFS_POSTINC: aliasMode = PM_POSTINC;
                OFS_POSTDEC: aliasMode = PM_POSTDEC;
                OFS_PREINC:  aliasMode = PM_PREINC;
                OFS_PLUSW:   aliasMode = PM_PLUSW;
                default:     aliasMode = PM_NONE;
            endcase
        end
    endfunction : aliasMode

    // ****************************************************************
    // Submodules
    // ****************************************************************
    cpoa_phase_gen u_phase (
        .clk   (clk),
        .rst_n (rst_n),
        .phase (phase)
    );

    cpoa_ptr_file u_ptr (
        .clk     (clk),
        .rst_n   (rst_n),
        .wrEn    (ptrWrEn),
        .wrIdx   (ptrWrIdx),
        .wrValue (ptrWrValue),
        .ptr0    (ptr0),
        .ptr1    (ptr1)
    );

    // ****************************************************************
    // Pipeline, addressing and register port
    // ****************************************************************
    // Fetch of the next word runs in the same cycle as execute of the current one
    always_comb begin
        logic [DA_W-1:0] raw;
        logic [DA_W-1:0] pv;
        logic [7:0]      opnd;
        logic [3:0]      kind;
        cpoa_pmode_t     pm;
        raw  = 12'h000;
        pv   = 12'h000;
        opnd = 8'h00;
        kind = ir[KIND_HI:KIND_LO];
        pm   = PM_NONE;
        next_pc       = pc;
        next_ir       = ir;
        next_fetchReg = fetchReg;
        next_flush    = flush;
        next_acc      = acc;
        next_bank     = bank;
        next_extEn    = extEn;
        next_effAddr  = effAddr;
        next_pmode    = pmode;
        next_pidx     = pidx;
        next_ptrNew   = ptrNew;
        next_mapLo    = mapLo;
        next_mapHi    = mapHi;
        next_result   = result;
        next_toAcc    = toAcc;
        next_toMem    = toMem;
        next_progAddr = progAddr;
        next_ramAddr  = ramAddr;
        next_ramRead  = 1'b0;
        next_ramWrite = 1'b0;
        next_ramWdata = ramWdata;
        ptrWrEn       = 1'b0;
        ptrWrIdx      = 1'b0;
        ptrWrValue    = 12'h000;

        // Software writes; an instruction that loads the bank later in this block wins
        if (regWrite && (regAddr == REG_CTRL)) begin
            next_extEn = regWdata[CTRL_EXT];
        end
        if (regWrite && (regAddr == REG_BANK)) begin
            next_bank = regWdata[BANK_W-1:0];
        end

        if (phase[0]) begin
            // Phase one: advance the program counter and latch the opcode
            next_pc = PC_W'(pc + 20'h00001);
            next_ir = flush ? NOP_WORD : fetchReg;
            next_flush = 1'b0;
            kind = next_ir[KIND_HI:KIND_LO];
            if (kind == K_FULL) begin
                raw = next_ir[11:0];
            end else begin
                raw = directAddr(next_ir, bank, extEn, ptr1);
            end
            pm = aliasMode(raw);
            pv = (raw[11:3] == PTR_BASE1[11:3]) ? ptr1 : ptr0;
            next_pidx  = (raw[11:3] == PTR_BASE1[11:3]);
            next_pmode = pm;
            next_mapLo = (raw == PTR_BASE0 + 12'h001) || (raw == PTR_BASE1 + 12'h001);
            next_mapHi = (raw == PTR_BASE0 + 12'h002) || (raw == PTR_BASE1 + 12'h002);
            next_ptrNew = pv;
            unique case (pm)
                PM_PLAIN:   next_effAddr = pv;
                PM_POSTINC: begin
                    next_effAddr = pv;
                    next_ptrNew  = DA_W'(pv + 12'h001);
                end
                PM_POSTDEC: begin
                    next_effAddr = pv;
                    next_ptrNew  = DA_W'(pv - 12'h001);
                end
                PM_PREINC: begin
                    next_effAddr = DA_W'(pv + 12'h001);
                    next_ptrNew  = DA_W'(pv + 12'h001);
                end
                PM_PLUSW:   next_effAddr = DA_W'(pv + {4'h0, acc});
                PM_NONE:    next_effAddr = raw;
            endcase
            next_ramAddr = next_effAddr;
            // Inherent, literal and jump words never touch data memory
            next_ramRead = ((kind == K_BYTE) || (kind == K_FULL))
                           && !next_mapLo && !next_mapHi;
        end

        if (phase[2]) begin
            // Phase three: operand is back, form result and destination
            if (mapLo) begin
                opnd = pidx ? ptr1[7:0] : ptr0[7:0];
            end else if (mapHi) begin
                opnd = {4'h0, (pidx ? ptr1[11:8] : ptr0[11:8])};
            end else begin
                opnd = ramRdata;
            end
            next_toAcc  = 1'b0;
            next_toMem  = 1'b0;
            next_result = opnd;
            unique case (kind)
                K_INH: begin
                    next_toAcc  = (ir[7:0] == INH_CLRACC);
                    next_result = 8'h00;
                end
                K_LIT: begin
                    next_toAcc  = 1'b1;
                    next_result = ir[7:0];
                end
                K_BYTE: begin
                    unique case (ir[FN_HI:FN_LO])
                        FN_MOV: next_result = opnd;
                        FN_INC: next_result = 8'(opnd + 8'h01);
                        FN_DEC: next_result = 8'(opnd - 8'h01);
                        FN_CLR: next_result = 8'h00;
                    endcase
                    next_toMem = ir[D_BIT];
                    next_toAcc = !ir[D_BIT];
                end
                K_STORE: begin
                    next_toMem  = 1'b1;
                    next_result = acc;
                end
                K_FULL:  next_toAcc = 1'b1;
                default: next_toAcc = 1'b0;
            endcase
            next_ramAddr  = effAddr;
            next_ramWdata = next_result;
            next_ramWrite = next_toMem && !mapLo && !mapHi;
        end

        if (phase[3]) begin
            // Phase four: commit results, latch the fetched word
            if (toAcc) begin
                next_acc = result;
            end
            if (kind == K_BANK) begin
                next_bank = ir[BANK_W-1:0];
            end
            if (pmode == PM_POSTINC || pmode == PM_POSTDEC || pmode == PM_PREINC) begin
                ptrWrEn    = 1'b1;
                ptrWrIdx   = pidx;
                ptrWrValue = ptrNew;
            end else if (toMem && (mapLo || mapHi)) begin
                ptrWrEn    = 1'b1;
                ptrWrIdx   = pidx;
                ptrWrValue = mapLo ? {ptrNew[11:8], result} : {result[3:0], ptrNew[7:0]};
            end
            next_fetchReg = progData;
            next_progAddr = pc;
            if (kind == K_JUMP) begin
                // Target low byte from this word, high bits from the word being fetched
                next_pc       = {progData[11:0], ir[7:0]};
                next_progAddr = next_pc;
                next_flush    = 1'b1;
            end
        end

        // Read data stand only in the cycle after the strobe
        next_regRdata = 32'h0000_0000;
        if (regRead) begin
            unique case (regAddr)
                REG_CTRL: next_regRdata = {31'h0000_0000, extEn};
                REG_BANK: next_regRdata = {28'h000_0000, bank};
                REG_PC:   next_regRdata = {12'h000, pc};
                REG_ACC:  next_regRdata = {24'h00_0000, acc};
                REG_IR:   next_regRdata = {16'h0000, ir};
                default:  next_regRdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc       <= PC_RST;
            ir       <= NOP_WORD;
            fetchReg <= NOP_WORD;
            flush    <= 1'b0;
            acc      <= ACC_RST;
            bank     <= BANK_RST;
            extEn    <= 1'b0;
            effAddr  <= 12'h000;
            pmode    <= PM_NONE;
            pidx     <= 1'b0;
            ptrNew   <= 12'h000;
            mapLo    <= 1'b0;
            mapHi    <= 1'b0;
            result   <= 8'h00;
            toAcc    <= 1'b0;
            toMem    <= 1'b0;
            progAddr <= PC_RST;
            ramAddr  <= 12'h000;
            ramRead  <= 1'b0;
            ramWrite <= 1'b0;
            ramWdata <= 8'h00;
            regRdata <= 32'h0000_0000;
        end else begin
            pc       <= next_pc;
            ir       <= next_ir;
            fetchReg <= next_fetchReg;
            flush    <= next_flush;
            acc      <= next_acc;
            bank     <= next_bank;
            extEn    <= next_extEn;
            effAddr  <= next_effAddr;
            pmode    <= next_pmode;
            pidx     <= next_pidx;
            ptrNew   <= next_ptrNew;
            mapLo    <= next_mapLo;
            mapHi    <= next_mapHi;
            result   <= next_result;
            toAcc    <= next_toAcc;
            toMem    <= next_toMem;
            progAddr <= next_progAddr;
            ramAddr  <= next_ramAddr;
            ramRead  <= next_ramRead;
            ramWrite <= next_ramWrite;
            ramWdata <= next_ramWdata;
            regRdata <= next_regRdata;
        end
    end

endmodule : cpoa_core_pipe

// ===== tb/cpoa_mem_model.sv
// Program memory and data RAM model.
// Assumes the bench preloads rom and ram.
`timescale 1ns/1ps
module cpoa_mem_model
    import cpoa_pkg::*;
(
    input  wire logic            clk,      // Clock
    input  wire logic [PC_W-1:0] progAddr, // Word address
    output logic      [IW_W-1:0] progData, // Word
    input  wire logic [DA_W-1:0] ramAddr,  // Data address
    input  wire logic            ramRead,  // Read strobe
    input  wire logic            ramWrite, // Write strobe
    input  wire logic [7:0]      ramWdata, // Write data
    output logic      [7:0]      ramRdata  // Read data
);
    logic [IW_W-1:0] rom [256];
    logic [7:0]      ram [4096];
    // Only 256 words modelled, so the address wraps
    assign progData = rom[progAddr[7:0]];
    // Data stands one clock, then inverts so stale use shows
    always @(posedge clk) begin
        ramRdata <= ramRead ? ram[ramAddr] : ~ramRdata;
        if (ramWrite) begin
            ram[ramAddr] <= ramWdata;
        end
    end
endmodule : cpoa_mem_model

// ===== tb/cpoa_core_pipe_properties.sv
// Port checks for the core pipeline, bound to its top.
// Assumes phase one is the first clock after reset.
`timescale 1ns/1ps
module cpoa_core_pipe_properties
    import cpoa_pkg::*;
(
    input wire logic            clk,      // Clock
    input wire logic            rst_n,    // Reset
    input wire logic [PC_W-1:0] progAddr, // Program address
    input wire logic [DA_W-1:0] ramAddr,  // Data address
    input wire logic            ramRead,  // Read strobe
    input wire logic            ramWrite, // Write strobe
    input wire logic [RA_W-1:0] regAddr,  // Port address
    input wire logic            regRead,  // Port read
    input wire logic [RD_W-1:0] regRdata  // Port data
);
    logic [1:0] ph;
    logic [1:0] next_ph;
    // Own phase count, so a slip in the design's sequencer shows
    always_comb next_ph = ph + 2'h1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph <= 2'h0;
        end else begin
            ph <= next_ph;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Strobe and address timing
    rd_phase_a: assert property (ramRead |-> ph == 2'h1)
        else $error("read off phase");
    wr_phase_a: assert property (ramWrite |-> ph == 2'h3)
        else $error("write off phase");
    rd_once_a: assert property (ramRead |=> !ramRead [*3])
        else $error("second read");
    addr_hold_a: assert property (ramRead |=> $stable(ramAddr) [*2])
        else $error("address moved");
    wr_addr_a: assert property (ramWrite |-> $stable(ramAddr))
        else $error("address moved at write");
    pc_edge_a: assert property ($changed(progAddr) |-> ph == 2'h0)
        else $error("counter moved mid cycle");
    // Counter steps in phase one, so after it the counter leads the fetch address by one
    pc_read_a: assert property (regRead && regAddr == REG_PC |=>
        regRdata == {12'h000, PC_W'($past(progAddr) + ($past(ph) != 2'h0))})
        else $error("counter readback");
    idle_zero_a: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data not cleared");
endmodule : cpoa_core_pipe_properties

bind cpoa_core_pipe cpoa_core_pipe_properties cpoa_core_pipe_properties_inst (
    .clk(clk), .rst_n(rst_n), .progAddr(progAddr), .ramAddr(ramAddr), .ramRead(ramRead),
    .ramWrite(ramWrite), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata));

// ===== tb/cpoa_core_pipe_tb.sv
// Bench: runs a short program, then register checks after reset.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ps
module cpoa_core_pipe_tb
    import cpoa_pkg::*;
;
    logic            clk, rst_n, ramRead, ramWrite, regWrite, regRead;
    logic [PC_W-1:0] progAddr;
    logic [IW_W-1:0] progData;
    logic [DA_W-1:0] ramAddr;
    logic [7:0]      ramWdata, ramRdata;
    logic [RA_W-1:0] regAddr;
    logic [RD_W-1:0] regWdata, regRdata;
    int              nErrors = 0, checksDone = 0;
    logic [15:0]     prog [14] = '{16'h5002, 16'h2734, 16'h2670, 16'h4123, 16'h3035,
        16'h1001, 16'h30EA, 16'h10FF, 16'h30E9, 16'h2EEE, 16'h20EA, 16'hE040, 16'hF000,
        16'h1099};
    cpoa_core_pipe cpoa_core_pipe_inst (.clk, .rst_n, .progAddr, .progData, .ramAddr,
        .ramRead, .ramWrite, .ramWdata, .ramRdata, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata);
    cpoa_mem_model cpoa_mem_model_inst (.clk, .progAddr, .progData, .ramAddr, .ramRead,
        .ramWrite, .ramWdata, .ramRdata);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask : cmp
    task automatic ram_chk(input logic [11:0] a, input logic [7:0] exp);
        cmp({24'h0, cpoa_mem_model_inst.ram[a]}, {24'h0, exp});
    endtask : ram_chk
    task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= wr;
        regRead  <= !wr;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead  <= 1'b0;
        @(negedge clk);
        if (!wr) cmp(regRdata, d);
    endtask : reg_io
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // Whole program; jump at word 11 must flush word 12 and skip word 13
    task automatic t_prog;
        repeat (100) @(posedge clk);
        ram_chk(12'h234, 8'h42);
        ram_chk(12'hF70, 8'h11);
        ram_chk(12'h035, 8'h5A);
        ram_chk(12'h1FF, 8'h00);
        reg_io(1'b0, REG_ACC, 32'h2);
        reg_io(1'b0, REG_ACC + 8'h1, 32'h0);
        $display("t_prog done");
    endtask : t_prog
    // Bank load of word 0 lands at the eighth edge, after these
    task automatic t_regs;
        do_reset;
        // Read in phase two, so the phase-one increment is already in
        reg_io(1'b0, REG_PC, 32'h1);
        reg_io(1'b1, REG_BANK, 32'h7);
        reg_io(1'b0, REG_BANK, 32'h7);
        reg_io(1'b1, REG_ACC, 32'h55);
        reg_io(1'b0, REG_ACC, 32'h0);
        reg_io(1'b1, REG_CTRL, 32'h1);
        reg_io(1'b0, REG_CTRL, 32'h1);
        $display("t_regs done");
    endtask : t_regs
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        rst_n    = 1'b0;
        regAddr  = 8'h00;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead  = 1'b0;
        for (int i = 0; i < 256; i++) begin
            cpoa_mem_model_inst.rom[i] = (i < 14) ? prog[i] : 16'h0000;
        end
        cpoa_mem_model_inst.rom[8'h40] = 16'hE040;
        cpoa_mem_model_inst.rom[8'h41] = 16'hF000;
        cpoa_mem_model_inst.ram[12'h234] = 8'h41;
        cpoa_mem_model_inst.ram[12'hF70] = 8'h10;
        cpoa_mem_model_inst.ram[12'h123] = 8'h5A;
        cpoa_mem_model_inst.ram[12'h1FF] = 8'h33;
        do_reset;
        t_prog;
        t_regs;
        give_verdict;
    end
    // Tests need about 145 clocks
    initial begin
        repeat (1000) @(posedge clk);
        nErrors++;
        give_verdict;
    end
endmodule : cpoa_core_pipe_tb
